// ==== pkg/pss_pkg.sv ====
// constants, types and helpers shared by the preset speed select block
// assumes a single 25 MHz clock domain and an APB register port
package pss_pkg;
  localparam int N_TERM    = 5;
  localparam int N_SPEED   = 16;
  localparam int IDX_W     = 4;
  localparam int FREQ_W    = 16;
  localparam int CODE_W    = 8;
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 32;

  typedef logic [FREQ_W-1:0] pss_freq_t;
  typedef logic [CODE_W-1:0] pss_code_t;
  typedef logic [IDX_W-1:0]  pss_idx_t;

  // terminal function codes, speed_sel_bit0 .. speed_sel_bit3
  localparam pss_code_t CODE_SEL_BIT0 = 8'h02;
  localparam pss_code_t CODE_UNUSED   = 8'h00;

  // freq_source_param and speed_method_param codes
  localparam logic [1:0] SRC_TERMINAL  = 2'h1;
  localparam logic [1:0] SRC_RESET     = 2'h0;
  localparam logic [1:0] METHOD_BINARY = 2'h0;

  // byte addresses
  localparam logic [ADDR_W-1:0] OFS_CTRL      = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_FREQ_SET  = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_EDIT      = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_STORE     = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_TABLE_RD  = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_FUNC_BASE = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_FUNC_LAST = 12'h030;

  // field positions
  localparam int CTRL_SRC_LSB  = 0;
  localparam int CTRL_MTH_LSB  = 2;
  localparam int EDIT_VAL_LSB  = 0;
  localparam int EDIT_IDX_LSB  = 16;
  localparam int STORE_BIT     = 0;
  localparam int STAT_FRQ_LSB  = 0;
  localparam int STAT_IDX_LSB  = 16;
  localparam int STAT_OVR_BIT  = 20;

  localparam pss_freq_t PRESET_RESET = 16'h0000;

  typedef struct packed {
    logic [1:0] src;
    logic [1:0] method;
  } pss_cfg_s;

  typedef struct packed {
    pss_idx_t idx;
    logic     active;
  } pss_sel_s;

  typedef struct packed {
    logic      en;
    pss_idx_t  idx;
    pss_freq_t val;
  } pss_wr_s;

  // one-hot of the speed select bit a terminal code carries
  function automatic logic [IDX_W-1:0] pss_code_bits(input pss_code_t code);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int b = 0; b < IDX_W; b++) begin
      if (code == CODE_SEL_BIT0 + pss_code_t'(b)) begin
        r[b] = 1'b1;
      end
    end
    return r;
  endfunction : pss_code_bits
endpackage : pss_pkg

// ==== core/pss_sel_decode.sv ====
// terminal synchroniser and speed index decoder
// assumes terminals are asynchronous pins; function codes come from same-clock registers
`timescale 1ns/100ps
module pss_sel_decode
  import pss_pkg::*;
(
  input  wire logic                         i_clk,
  input  wire logic                         i_nrst,
  input  wire logic                         i_ce,
  input  wire logic [N_TERM-1:0]            i_term,
  input  wire logic [N_TERM-1:0][CODE_W-1:0] i_func,
  output pss_sel_s                          o_sel
);
  logic [N_TERM-1:0] meta_q;
  logic [N_TERM-1:0] sync_q;
  pss_sel_s          sel_q;
  pss_sel_s          sel_d;

  always_comb begin
    sel_d = sel_q;
    if (i_ce) begin
      sel_d.idx = '0;
      for (int t = 0; t < N_TERM; t++) begin
        if (sync_q[t]) begin
          sel_d.idx = sel_d.idx | pss_code_bits(i_func[t]);
        end
      end
      sel_d.active = |sel_d.idx;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_q <= '0;
      sync_q <= '0;
      sel_q  <= '0;
    end else begin
      if (i_ce) begin
        meta_q <= i_term;
        sync_q <= meta_q;
      end
      sel_q <= sel_d;
    end
  end

  assign o_sel = sel_q;
endmodule : pss_sel_decode

// ==== core/pss_preset_table.sv ====
// sixteen-entry preset frequency storage, one write and two read ports
// assumes writes come only from the store action of the register block
`timescale 1ns/100ps
module pss_preset_table
  import pss_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_nrst,
  input  wire logic      i_ce,
  input  pss_wr_s        i_wr,
  input  pss_idx_t       i_sel_idx,
  input  pss_idx_t       i_rd_idx,
  output pss_freq_t      o_sel_freq,
  output pss_freq_t      o_rd_freq
);
  pss_freq_t mem_q [N_SPEED];
  pss_freq_t mem_d [N_SPEED];

  always_comb begin
    for (int i = 0; i < N_SPEED; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (i_ce && i_wr.en) begin
      mem_d[i_wr.idx] = i_wr.val;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < N_SPEED; i++) begin
        mem_q[i] <= PRESET_RESET;
      end
    end else begin
      for (int i = 0; i < N_SPEED; i++) begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  assign o_sel_freq = mem_q[i_sel_idx];
  assign o_rd_freq  = mem_q[i_rd_idx];
endmodule : pss_preset_table

// ==== core/pss_preset_speed_select.sv ====
// preset speed select top: APB registers, override mux, output frequency
// assumes a 25 MHz clock, asynchronous active-low reset, APB master on same clock
`timescale 1ns/100ps
module pss_preset_speed_select
  import pss_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_ce,
  input  wire logic [N_TERM-1:0] i_term,
  input  wire pss_freq_t         i_term_freq,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [DATA_W-1:0] i_pwdata,
  output logic [DATA_W-1:0]      o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  output pss_freq_t              o_out_freq,
  output logic                   o_override,
  output pss_idx_t               o_speed_idx
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DONE = 2'b10
  } pss_apb_e;

  // address decode shared by read and write paths
  function automatic logic is_func(input logic [ADDR_W-1:0] a);
    return (a >= OFS_FUNC_BASE) && (a <= OFS_FUNC_LAST) && (a[1:0] == 2'h0);
  endfunction : is_func

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return (a == OFS_CTRL) || (a == OFS_FREQ_SET) || (a == OFS_EDIT) ||
           (a == OFS_STORE) || (a == OFS_TABLE_RD) || (a == OFS_STATUS) || is_func(a);
  endfunction : addr_ok

  function automatic int func_slot(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - OFS_FUNC_BASE;
    return int'(d[ADDR_W-1:2]);
  endfunction : func_slot

  // register state
  pss_cfg_s                    cfg_q;
  pss_cfg_s                    cfg_d;
  pss_freq_t                   freq_set_q;
  pss_freq_t                   freq_set_d;
  logic [N_TERM-1:0][CODE_W-1:0] func_q;
  logic [N_TERM-1:0][CODE_W-1:0] func_d;
  pss_idx_t                    edit_idx_q;
  pss_idx_t                    edit_idx_d;
  pss_freq_t                   edit_val_q;
  pss_freq_t                   edit_val_d;
  pss_wr_s                     wr;

  // bus response state
  pss_apb_e                    st_q;
  pss_apb_e                    st_d;
  logic [DATA_W-1:0]           prdata_q;
  logic [DATA_W-1:0]           prdata_d;
  logic                        pready_q;
  logic                        pready_d;
  logic                        pslverr_q;
  logic                        pslverr_d;

  // output state
  pss_freq_t                   out_freq_q;
  pss_freq_t                   out_freq_d;
  logic                        override_q;
  logic                        override_d;
  pss_idx_t                    speed_idx_q;
  pss_idx_t                    speed_idx_d;

  pss_sel_s                    sel;
  pss_freq_t                   sel_freq;
  pss_freq_t                   rd_freq;
  logic                        wr_take;

  pss_sel_decode u_decode (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_ce   (i_ce),
    .i_term (i_term),
    .i_func (func_q),
    .o_sel  (sel)
  );

  pss_preset_table u_table (
    .i_clk      (i_clk),
    .i_nrst     (i_nrst),
    .i_ce       (i_ce),
    .i_wr       (wr),
    .i_sel_idx  (sel.idx),
    .i_rd_idx   (edit_idx_q),
    .o_sel_freq (sel_freq),
    .o_rd_freq  (rd_freq)
  );

  // write takes effect on the edge where the master sees pready
  assign wr_take = i_ce && (st_q == ST_DONE) && i_psel && i_penable && i_pwrite &&
                   addr_ok(i_paddr);

  // apb response sequencing and read data
  always_comb begin
    st_d      = st_q;
    prdata_d  = prdata_q;
    pready_d  = pready_q;
    pslverr_d = pslverr_q;
    if (i_ce) begin
      case (st_q)
        ST_IDLE: begin
          pready_d  = 1'b0;
          pslverr_d = 1'b0;
          if (i_psel && i_penable) begin
            st_d      = ST_DONE;
            pready_d  = 1'b1;
            pslverr_d = !addr_ok(i_paddr);
            prdata_d  = '0;
            if (!i_pwrite) begin
              if (i_paddr == OFS_CTRL) begin
                prdata_d[CTRL_SRC_LSB +: 2] = cfg_q.src;
                prdata_d[CTRL_MTH_LSB +: 2] = cfg_q.method;
              end else if (i_paddr == OFS_FREQ_SET) begin
                prdata_d[FREQ_W-1:0] = freq_set_q;
              end else if (i_paddr == OFS_EDIT) begin
                prdata_d[EDIT_VAL_LSB +: FREQ_W] = edit_val_q;
                prdata_d[EDIT_IDX_LSB +: IDX_W]  = edit_idx_q;
              end else if (i_paddr == OFS_TABLE_RD) begin
                prdata_d[FREQ_W-1:0] = rd_freq;
              end else if (i_paddr == OFS_STATUS) begin
                prdata_d[STAT_FRQ_LSB +: FREQ_W] = out_freq_q;
                prdata_d[STAT_IDX_LSB +: IDX_W]  = speed_idx_q;
                prdata_d[STAT_OVR_BIT]           = override_q;
              end else if (is_func(i_paddr)) begin
                prdata_d[CODE_W-1:0] = func_q[func_slot(i_paddr)];
              end
            end
          end
        end
        ST_DONE: begin
          st_d      = ST_IDLE;
          pready_d  = 1'b0;
          pslverr_d = 1'b0;
        end
        default: begin
          st_d      = ST_IDLE;
          pready_d  = 1'b0;
          pslverr_d = 1'b0;
        end
      endcase
    end
  end

  // software-written configuration and preset editing
  always_comb begin
    cfg_d      = cfg_q;
    freq_set_d = freq_set_q;
    func_d     = func_q;
    edit_idx_d = edit_idx_q;
    edit_val_d = edit_val_q;
    wr         = '0;
    if (wr_take) begin
      if (i_paddr == OFS_CTRL) begin
        cfg_d.src    = i_pwdata[CTRL_SRC_LSB +: 2];
        cfg_d.method = i_pwdata[CTRL_MTH_LSB +: 2];
      end else if (i_paddr == OFS_FREQ_SET) begin
        freq_set_d = i_pwdata[FREQ_W-1:0];
      end else if (i_paddr == OFS_EDIT) begin
        edit_val_d = i_pwdata[EDIT_VAL_LSB +: FREQ_W];
        edit_idx_d = i_pwdata[EDIT_IDX_LSB +: IDX_W];
      end else if (i_paddr == OFS_STORE) begin
        wr.en  = i_pwdata[STORE_BIT];
        wr.idx = edit_idx_q;
        wr.val = edit_val_q;
      end else if (is_func(i_paddr)) begin
        func_d[func_slot(i_paddr)] = i_pwdata[CODE_W-1:0];
      end
    end
  end

  // frequency selection and override
  always_comb begin
    out_freq_d  = out_freq_q;
    override_d  = override_q;
    speed_idx_d = speed_idx_q;
    if (i_ce) begin
      speed_idx_d = sel.idx;
      override_d  = (cfg_q.src == SRC_TERMINAL) && (cfg_q.method == METHOD_BINARY) &&
                    sel.active;
      if (cfg_q.src == SRC_TERMINAL) begin
        if (override_d) begin
          out_freq_d = sel_freq;
        end else begin
          out_freq_d = i_term_freq;
        end
      end else begin
        out_freq_d = freq_set_q;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_q       <= '{src: SRC_RESET, method: METHOD_BINARY};
      freq_set_q  <= PRESET_RESET;
      func_q      <= {N_TERM{CODE_UNUSED}};
      edit_idx_q  <= '0;
      edit_val_q  <= PRESET_RESET;
      st_q        <= ST_IDLE;
      prdata_q    <= '0;
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
      out_freq_q  <= PRESET_RESET;
      override_q  <= 1'b0;
      speed_idx_q <= '0;
    end else begin
      cfg_q       <= cfg_d;
      freq_set_q  <= freq_set_d;
      func_q      <= func_d;
      edit_idx_q  <= edit_idx_d;
      edit_val_q  <= edit_val_d;
      st_q        <= st_d;
      prdata_q    <= prdata_d;
      pready_q    <= pready_d;
      pslverr_q   <= pslverr_d;
      out_freq_q  <= out_freq_d;
      override_q  <= override_d;
      speed_idx_q <= speed_idx_d;
    end
  end

  assign o_prdata    = prdata_q;
  assign o_pready    = pready_q;
  assign o_pslverr   = pslverr_q;
  assign o_out_freq  = out_freq_q;
  assign o_override  = override_q;
  assign o_speed_idx = speed_idx_q;
endmodule : pss_preset_speed_select

// ==== sim/pss_switch_model.sv ====
// selection switches wired to the intelligent terminals
// assumes the bench gives the wanted speed index on a clock edge
`timescale 1ns/100ps
module pss_switch_model
  import pss_pkg::*;
(
  input  wire logic         i_clk,
  input  wire pss_idx_t     i_idx,
  input  wire logic         i_spare,
  output logic [N_TERM-1:0] o_term
);
  // terminals 0..4 carry bit3, bit2, spare, bit1, bit0
  always_ff @(posedge i_clk) begin
    o_term <= {i_idx[0], i_idx[1], i_spare, i_idx[2], i_idx[3]};
  end
endmodule : pss_switch_model

// ==== sim/pss_checker.sv ====
// assertions on the preset speed select top ports
// assumes i_ce is high while an apb transfer is taken
`timescale 1ns/100ps
module pss_checker
  import pss_pkg::*;
(
  input wire logic              i_clk,
  input wire logic              i_nrst,
  input wire logic              i_ce,
  input wire logic [N_TERM-1:0] i_term,
  input wire pss_freq_t         i_term_freq,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [DATA_W-1:0] i_pwdata,
  input wire logic [DATA_W-1:0] o_prdata,
  input wire logic              o_pready,
  input wire logic              o_pslverr,
  input wire pss_freq_t         o_out_freq,
  input wire logic              o_override,
  input wire pss_idx_t          o_speed_idx
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic mapped;
  assign mapped = (i_paddr inside {OFS_CTRL, OFS_FREQ_SET, OFS_EDIT, OFS_STORE, OFS_TABLE_RD,
    OFS_STATUS}) || (i_paddr >= OFS_FUNC_BASE && i_paddr <= OFS_FUNC_LAST && i_paddr[1:0] == 2'h0);
  a_ready_wait: assert property ($rose(i_penable) && i_psel && i_ce |=> o_pready)
    else $error("no ready one cycle after access");
  a_ready_pulse: assert property (o_pready && i_ce |=> !o_pready)
    else $error("ready longer than one cycle");
  a_idle_quiet: assert property (!i_psel && i_ce |=> !o_pready)
    else $error("ready without a transfer");
  a_err_unmapped: assert property (o_pready && !mapped |-> o_pslverr && o_prdata == '0)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (o_pready && mapped |-> !o_pslverr)
    else $error("mapped access refused");
  a_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("error outside ready");
  a_ovr_index: assert property (o_override |-> o_speed_idx != '0)
    else $error("override with index zero");
  a_idx_hold: assert property (
    (!i_psel && i_ce && $stable(i_term))[*6] |-> $stable(o_speed_idx) && $stable(o_override))
    else $error("index moved with quiet terminals");
  a_ce_freeze: assert property (!i_ce |=> $stable(o_speed_idx) && $stable(o_out_freq))
    else $error("outputs moved with enable low");
endmodule : pss_checker
bind pss_preset_speed_select pss_checker u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
  .i_term(i_term), .i_term_freq(i_term_freq), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_out_freq(o_out_freq),
  .o_override(o_override), .o_speed_idx(o_speed_idx));

// ==== sim/pss_preset_speed_select_tb.sv ====
// self-checking bench for the preset speed select top
// assumes the switch model on the terminals and an apb master here
`timescale 1ns/100ps
module pss_preset_speed_select_tb;
  import pss_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, spare = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, ovr, err;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, rd;
  logic [N_TERM-1:0] term;
  pss_freq_t out_f, tfreq = 16'h0555;
  pss_freq_t tbl [N_SPEED];
  pss_idx_t idx, sidx = '0;
  pss_code_t fc [N_TERM] = '{8'h05, 8'h04, 8'h00, 8'h03, 8'h02};
  int n_fail = 0, n_tests = 0;
  `define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
  always #20 clk = ~clk;
  pss_switch_model sw (.i_clk(clk), .i_idx(sidx), .i_spare(spare), .o_term(term));
  pss_preset_speed_select dut (.i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_term(term),
    .i_term_freq(tfreq), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_out_freq(out_f), .o_override(ovr), .o_speed_idx(idx));
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic ee);
    apb(1'b0, a, '0);
    `CHK(rd, e)
    `CHK(err, ee)
  endtask : rchk
  task automatic sel(input pss_idx_t i, input logic s);
    @(posedge clk);
    sidx <= i;
    spare <= s;
  endtask : sel
  task automatic settle(input pss_freq_t f, input logic o);
    repeat (8) @(posedge clk);
    #1;
    `CHK(out_f, f)
    `CHK(ovr, o)
  endtask : settle
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  initial begin
    #400000;
    n_fail++;
    summarize();
  end
  initial begin
    for (int i = 0; i < N_SPEED; i++) tbl[i] = 16'h1000 + 16'(i * 17);
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rchk(OFS_CTRL, '0, 1'b0);
    rchk(OFS_FUNC_BASE, '0, 1'b0);
    rchk(OFS_TABLE_RD, '0, 1'b0);
    rchk(12'h018, '0, 1'b1);
    rchk(12'h002, '0, 1'b1);
    $display("test reset done");
    for (int i = 0; i < N_SPEED; i++) begin
      apb(1'b1, OFS_EDIT, {12'h000, pss_idx_t'(i), tbl[i]});
      apb(1'b1, OFS_STORE, 32'h00000001);
    end
    apb(1'b1, OFS_EDIT, 32'h0005BEEF);
    rchk(OFS_TABLE_RD, {16'h0000, tbl[5]}, 1'b0);
    apb(1'b1, OFS_STORE, 32'h00000000);
    rchk(OFS_TABLE_RD, {16'h0000, tbl[5]}, 1'b0);
    apb(1'b1, OFS_STORE, 32'h00000001);
    tbl[5] = 16'hBEEF;
    rchk(OFS_TABLE_RD, {16'h0000, tbl[5]}, 1'b0);
    $display("test store done");
    apb(1'b1, OFS_CTRL, 32'h00000001);
    for (int t = 0; t < N_TERM; t++) apb(1'b1, OFS_FUNC_BASE + 12'(4 * t), {24'h0, fc[t]});
    rchk(OFS_FUNC_BASE + 12'h004, 32'h00000004, 1'b0);
    settle(tfreq, 1'b0);
    for (int i = 0; i < N_SPEED; i++) begin
      sel(pss_idx_t'(i), 1'b0);
      settle(i == 0 ? tfreq : tbl[i], i != 0);
      `CHK(idx, pss_idx_t'(i))
    end
    $display("test select done");
    sel(4'h6, 1'b0);
    repeat (4) @(posedge clk);
    #1;
    `CHK(idx, 4'hF)
    @(posedge clk);
    #1;
    `CHK(idx, 4'h6)
    `CHK(out_f, tbl[6])
    sel(4'h0, 1'b1);
    tfreq <= 16'h0777;
    settle(16'h0777, 1'b0);
    `CHK(idx, 4'h0)
    sel(4'h3, 1'b1);
    settle(tbl[3], 1'b1);
    rchk(OFS_STATUS, {11'h000, 1'b1, 4'h3, tbl[3]}, 1'b0);
    apb(1'b1, OFS_STATUS, '0);
    `CHK(err, 1'b0)
    $display("test override done");
    @(posedge clk);
    ce <= 1'b0;
    sidx <= 4'h2;
    repeat (10) @(posedge clk);
    #1;
    `CHK(idx, 4'h3)
    @(posedge clk);
    ce <= 1'b1;
    settle(tbl[2], 1'b1);
    apb(1'b1, OFS_CTRL, 32'h00000005);
    settle(16'h0777, 1'b0);
    apb(1'b1, OFS_FREQ_SET, 32'h00000ABC);
    apb(1'b1, OFS_CTRL, 32'h00000000);
    settle(16'h0ABC, 1'b0);
    $display("test source done");
    summarize();
  end
endmodule : pss_preset_speed_select_tb
